// ==== hw/rbu_pkg.sv ====
// constants and types for the relative branch unit
package rbu_pkg;
  localparam int RBU_WORD_W = 16;
  localparam int RBU_PC_W = 21;
  localparam int RBU_COND_OFS_W = 8;
  localparam int RBU_JUMP_OFS_W = 11;
  localparam int RBU_COND_OP_LSB = 8;
  localparam int RBU_JUMP_OP_LSB = 11;
  localparam logic [7:0] RBU_OP_OVCLR = 8'hE5;
  localparam logic [7:0] RBU_OP_NONZERO = 8'hE1;
  localparam logic [4:0] RBU_OP_JUMP = 5'h1A;
  localparam logic [RBU_PC_W-1:0] RBU_PC_STEP = 21'h0_0002;

  typedef enum logic [1:0] {
    RBU_Q1 = 2'h0,
    RBU_Q2 = 2'h1,
    RBU_Q3 = 2'h2,
    RBU_Q4 = 2'h3
  } rbu_phase_e;

  typedef enum logic [1:0] {
    RBU_NONE = 2'h0,
    RBU_OVCLR = 2'h1,
    RBU_NONZERO = 2'h2,
    RBU_JUMP = 2'h3
  } rbu_kind_e;

  typedef enum logic {
    RBU_EXEC = 1'b0,
    RBU_FLUSH = 1'b1
  } rbu_state_e;
endpackage

// ==== hw/rbu_branch_unit.sv ====
// relative branch execution unit: decode, target, pc write and prefetch flush
`timescale 1ns/1ps
module rbu_branch_unit
  import rbu_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic instr_valid,
  input wire logic [RBU_WORD_W-1:0] instr_word,
  input wire logic [RBU_PC_W-1:0] branch_addr,
  input wire logic flag_overflow,
  input wire logic flag_zero,
  output logic [1:0] phase,
  output logic pc_load,
  output logic [RBU_PC_W-1:0] pc_value,
  output logic branch_taken,
  output logic flush_fetch,
  output logic busy
);

  function automatic rbu_kind_e rbu_decode(input logic [RBU_WORD_W-1:0] w);
    rbu_decode = RBU_NONE;
    if (w[RBU_WORD_W-1 -: 8] == RBU_OP_OVCLR) begin
      rbu_decode = RBU_OVCLR;
    end else if (w[RBU_WORD_W-1 -: 8] == RBU_OP_NONZERO) begin
      rbu_decode = RBU_NONZERO;
    end else if (w[RBU_WORD_W-1 -: 5] == RBU_OP_JUMP) begin
      rbu_decode = RBU_JUMP;
    end
  endfunction

  rbu_phase_e phase_reg;
  rbu_state_e state_reg;
  rbu_kind_e kind_reg;
  logic [RBU_WORD_W-1:0] word_reg;
  logic [RBU_PC_W-1:0] addr_reg;
  logic [RBU_PC_W-1:0] offset_reg;
  logic [RBU_PC_W-1:0] target_reg;
  logic cond_reg;
  logic ov_reg;
  logic zero_reg;
  logic pc_load_reg;
  logic [RBU_PC_W-1:0] pc_value_reg;
  logic taken_reg;
  logic flush_reg;

  // four quarters per instruction cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      phase_reg <= RBU_Q1;
    end else begin
      unique case (phase_reg)
        RBU_Q1: phase_reg <= RBU_Q2;
        RBU_Q2: phase_reg <= RBU_Q3;
        RBU_Q3: phase_reg <= RBU_Q4;
        RBU_Q4: phase_reg <= RBU_Q1;
      endcase
    end
  end

  // Q1: decode; words offered during a flush cycle are dropped
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      kind_reg <= RBU_NONE;
      word_reg <= '0;
      addr_reg <= '0;
      ov_reg <= 1'b0;
      zero_reg <= 1'b0;
    end else if (phase_reg == RBU_Q1) begin
      kind_reg <= (state_reg == RBU_EXEC && instr_valid) ? rbu_decode(instr_word) : RBU_NONE;
      word_reg <= instr_word;
      addr_reg <= branch_addr;
      ov_reg <= flag_overflow;
      zero_reg <= flag_zero;
    end
  end

  // Q2: read the offset literal, sign extend and double
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      offset_reg <= '0;
    end else if (phase_reg == RBU_Q2) begin
      if (kind_reg == RBU_JUMP) begin
        offset_reg <= {{(RBU_PC_W-RBU_JUMP_OFS_W-1){word_reg[RBU_JUMP_OFS_W-1]}},
                       word_reg[RBU_JUMP_OFS_W-1:0], 1'b0};
      end else begin
        offset_reg <= {{(RBU_PC_W-RBU_COND_OFS_W-1){word_reg[RBU_COND_OFS_W-1]}},
                       word_reg[RBU_COND_OFS_W-1:0], 1'b0};
      end
    end
  end

  // Q3: target and condition; flags are only read, never written
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      target_reg <= '0;
      cond_reg <= 1'b0;
    end else if (phase_reg == RBU_Q3) begin
      target_reg <= addr_reg + RBU_PC_STEP + offset_reg;
      unique case (kind_reg)
        RBU_OVCLR: cond_reg <= !ov_reg;
        RBU_NONZERO: cond_reg <= !zero_reg;
        RBU_JUMP: cond_reg <= 1'b1;
        RBU_NONE: cond_reg <= 1'b0;
      endcase
    end
  end

  // Q4: write pc; a pulse of one quarter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pc_load_reg <= 1'b0;
      pc_value_reg <= '0;
      taken_reg <= 1'b0;
    end else if (phase_reg == RBU_Q4 && kind_reg != RBU_NONE) begin
      pc_load_reg <= 1'b1;
      pc_value_reg <= cond_reg ? target_reg : addr_reg + RBU_PC_STEP;
      taken_reg <= cond_reg;
    end else begin
      pc_load_reg <= 1'b0;
      taken_reg <= 1'b0;
    end
  end

  // taken branches spend one whole idle cycle discarding the prefetch
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= RBU_EXEC;
      flush_reg <= 1'b0;
    end else if (phase_reg == RBU_Q4) begin
      unique case (state_reg)
        RBU_EXEC: begin
          if (kind_reg != RBU_NONE && cond_reg) begin
            state_reg <= RBU_FLUSH;
            flush_reg <= 1'b1;
          end
        end
        RBU_FLUSH: begin
          state_reg <= RBU_EXEC;
          flush_reg <= 1'b0;
        end
      endcase
    end
  end

  assign phase = phase_reg;
  assign pc_load = pc_load_reg;
  assign pc_value = pc_value_reg;
  assign branch_taken = taken_reg;
  assign flush_fetch = flush_reg;
  assign busy = flush_reg;

  // helper: a word offered at Q1 is taken for decode (exec state, valid high)
  logic dec_ok;
  assign dec_ok = (phase_reg == RBU_Q1) && (state_reg == RBU_EXEC) && instr_valid;

  sequence s_ov_clear;
    dec_ok && rbu_decode(instr_word) == RBU_OVCLR && !flag_overflow;
  endsequence
  sequence s_ov_set;
    dec_ok && rbu_decode(instr_word) == RBU_OVCLR && flag_overflow;
  endsequence
  sequence s_nz_clear;
    dec_ok && rbu_decode(instr_word) == RBU_NONZERO && !flag_zero;
  endsequence
  sequence s_jump;
    dec_ok && rbu_decode(instr_word) == RBU_JUMP;
  endsequence
  sequence s_taken_load;
    ##4 (pc_load && branch_taken);
  endsequence

  a_ovclr_taken: assert property (@(posedge ref_clk) disable iff (reset)
    s_ov_clear |-> s_taken_load)
    else $error("overflow-clear branch not taken with flag zero");
  a_ovset_fall: assert property (@(posedge ref_clk) disable iff (reset)
    s_ov_set |-> ##4 (pc_load && !branch_taken))
    else $error("overflow-clear branch taken with flag set");
  a_nonzero_taken: assert property (@(posedge ref_clk) disable iff (reset)
    s_nz_clear |-> s_taken_load)
    else $error("nonzero branch not taken with zero flag clear");
  a_zero_fall: assert property (@(posedge ref_clk) disable iff (reset)
    dec_ok && rbu_decode(instr_word) == RBU_NONZERO && flag_zero
    |-> ##4 (pc_load && !branch_taken && pc_value == $past(branch_addr, 4) + RBU_PC_STEP))
    else $error("fall-through did not advance pc by one word");
  a_target_even: assert property (@(posedge ref_clk) disable iff (reset)
    (pc_load && branch_taken) |-> pc_value[0] == $past(addr_reg[0]))
    else $error("doubled offset changed address parity");
  a_jump_target: assert property (@(posedge ref_clk) disable iff (reset)
    s_jump |-> ##4 (pc_load && branch_taken && pc_value == $past(branch_addr, 4)
      + RBU_PC_STEP + {{(RBU_PC_W-RBU_JUMP_OFS_W-1){$past(instr_word[RBU_JUMP_OFS_W-1], 4)}},
      $past(instr_word[RBU_JUMP_OFS_W-1:0], 4), 1'b0}))
    else $error("relative jump target wrong");
  a_flush_len: assert property (@(posedge ref_clk) disable iff (reset)
    (pc_load && branch_taken) |-> flush_fetch [*4] ##1 !flush_fetch)
    else $error("flush cycle not exactly one instruction cycle");
  a_no_flush_fall: assert property (@(posedge ref_clk) disable iff (reset)
    (pc_load && !branch_taken && !flush_fetch) |-> !flush_fetch [*4])
    else $error("not-taken branch stretched to two cycles");
  a_load_quarter: assert property (@(posedge ref_clk) disable iff (reset)
    pc_load |-> phase_reg == RBU_Q1 && $past(phase_reg) == RBU_Q4)
    else $error("pc written outside the fourth quarter");
  a_flush_drop: assert property (@(posedge ref_clk) disable iff (reset)
    (phase_reg == RBU_Q1 && flush_fetch) |-> ##4 !pc_load)
    else $error("prefetched word executed during flush");

  // conditional forms take only the low byte; a wider field would move the target
  a_cond_target: assert property (@(posedge ref_clk) disable iff (reset)
    s_nz_clear |-> ##4 (pc_load && pc_value == $past(branch_addr, 4) + RBU_PC_STEP
      + {{(RBU_PC_W-RBU_COND_OFS_W-1){$past(instr_word[RBU_COND_OFS_W-1], 4)}},
      $past(instr_word[RBU_COND_OFS_W-1:0], 4), 1'b0}))
    else $error("conditional branch target wrong");

endmodule

// ==== test/rbu_branch_unit_tb.sv ====
// self-checking bench for the relative branch unit
`timescale 1ns/1ps
module rbu_branch_unit_tb
  import rbu_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic instr_valid = 1'b0;
  logic [RBU_WORD_W-1:0] instr_word = 16'h0000;
  logic [RBU_PC_W-1:0] branch_addr = 21'h00_0000;
  logic flag_overflow = 1'b0;
  logic flag_zero = 1'b0;
  logic [1:0] phase;
  logic pc_load;
  logic branch_taken;
  logic flush_fetch;
  logic busy;
  logic [RBU_PC_W-1:0] pc_value;
  int fail_count = 0;
  int checked = 0;

  rbu_branch_unit rbu_branch_unit_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .instr_valid(instr_valid),
    .instr_word(instr_word),
    .branch_addr(branch_addr),
    .flag_overflow(flag_overflow),
    .flag_zero(flag_zero),
    .phase(phase),
    .pc_load(pc_load),
    .pc_value(pc_value),
    .branch_taken(branch_taken),
    .flush_fetch(flush_fetch),
    .busy(busy)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cbit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic cpc(input string name, input logic [RBU_PC_W-1:0] exp,
                     input logic [RBU_PC_W-1:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // valid is held through the flush cycle so its Q1 offer must be refused
  task automatic go(input logic [15:0] word, input logic [20:0] addr, input logic ov,
                    input logic z, input logic ld, input logic tk, input int off);
    logic [RBU_PC_W-1:0] tgt;
    int n;
    tgt = addr + RBU_PC_STEP + (tk ? 21'(2 * off) : 21'h00_0000);
    @(posedge ref_clk);
    instr_word <= word;
    branch_addr <= addr;
    flag_overflow <= ov;
    flag_zero <= z;
    instr_valid <= 1'b1;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(phase === 2'h0 && busy === 1'b0) && n < 20);
    for (n = 1; n <= 8; n++) begin
      @(posedge ref_clk);
      if (n == (tk ? 8 : 1)) instr_valid <= 1'b0;
      @(negedge ref_clk);
      cbit("phase", 1'b1, phase === 2'(n % 4));
      cbit("pc_load", ld && n == 4, pc_load);
      cbit("flush_fetch", tk && n >= 4 && n <= 7, flush_fetch);
      cbit("busy", tk && n >= 4 && n <= 7, busy);
      cbit("branch_taken", ld && tk && n == 4, branch_taken);
      if (ld && n == 4) begin
        cpc("pc_value", tgt, pc_value);
      end
    end
  endtask

  task automatic t_ovclr();
    go({RBU_OP_OVCLR, 8'h7F}, 21'h00_0100, 1'b0, 1'b1, 1'b1, 1'b1, 127);
    go({RBU_OP_OVCLR, 8'h80}, 21'h00_0100, 1'b1, 1'b0, 1'b1, 1'b0, -128);
  endtask

  task automatic t_nonzero();
    go({RBU_OP_NONZERO, 8'h80}, 21'h00_0040, 1'b1, 1'b0, 1'b1, 1'b1, -128);
    go({RBU_OP_NONZERO, 8'h7F}, 21'h00_0040, 1'b0, 1'b1, 1'b1, 1'b0, 127);
  endtask

  task automatic t_jump();
    go({RBU_OP_JUMP, 11'h400}, 21'h00_1000, 1'b1, 1'b1, 1'b1, 1'b1, -1024);
    go({RBU_OP_JUMP, 11'h3FF}, 21'h1F_FFF0, 1'b0, 1'b0, 1'b1, 1'b1, 1023);
  endtask

  // near-miss encodings must produce no pc write
  task automatic t_refused();
    go(16'hE300, 21'h00_0200, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    go(16'hD800, 21'h00_0200, 1'b0, 1'b0, 1'b0, 1'b0, 0);
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    t_ovclr();
    t_nonzero();
    t_jump();
    t_refused();
    final_report();
  end

  initial begin
    #20000;
    fail_count++;
    final_report();
  end
endmodule
